// *** sar_adc_pkg.sv ***
// Shared constants for the SAR converter control block.
package sar_adc_pkg;
   // Register addresses on the special-function register port.
   localparam logic [7:0] CONFIG_ADDR = 8'hbc; // Converter configuration.
   localparam logic [7:0] RESULT_LOW_ADDR = 8'hbe; // Result low byte.
   localparam logic [7:0] RESULT_HIGH_ADDR = 8'hbf; // Result high byte.
   localparam logic [7:0] UPPER_LOW_ADDR = 8'hc4; // Greater-than word, low byte.
   localparam logic [7:0] UPPER_HIGH_ADDR = 8'hc5; // Greater-than word, high byte.
   localparam logic [7:0] LOWER_LOW_ADDR = 8'hc6; // Less-than word, low byte.
   localparam logic [7:0] LOWER_HIGH_ADDR = 8'hc7; // Less-than word, high byte.
   localparam logic [7:0] CONTROL_ADDR = 8'he8; // Converter control.
   // Reset values.
   localparam logic [7:0] CONFIG_RESET = 8'hf8; // Slowest divider, unity gain.
   localparam logic [7:0] UPPER_RESET = 8'hff; // Greater-than bytes.
   localparam logic [7:0] ZERO_BYTE = 8'h00; // Other bytes and unmapped reads.
   // Field positions in the control register.
   localparam int ENABLE_BIT = 7; // Converter enable.
   localparam int TRACK_BIT = 6; // Track mode select.
   localparam int DONE_BIT = 5; // Conversion done flag.
   localparam int BUSY_BIT = 4; // Busy bit.
   localparam int SOURCE_MSB = 3; // Start source, upper bit.
   localparam int SOURCE_LSB = 2; // Start source, lower bit.
   localparam int WINDOW_BIT = 1; // Window match flag.
   localparam int LJUST_BIT = 0; // Left justify select.
   // Field positions in the configuration register.
   localparam int DIV_MSB = 7; // Divider field, upper bit.
   localparam int DIV_LSB = 3; // Divider field, lower bit.
   localparam int GAIN_MSB = 2; // Gain field, upper bit.
   // Start source codes.
   localparam logic [1:0] SRC_WRITE = 2'h0; // Busy bit write of one.
   localparam logic [1:0] SRC_TIMER3 = 2'h1; // Timer 3 overflow.
   localparam logic [1:0] SRC_PIN = 2'h2; // External start pin.
   localparam logic [1:0] SRC_TIMER2 = 2'h3; // Timer 2 overflow.
   // Gain expressed as twice the amplifier gain.
   localparam logic [5:0] GAIN_X2_HALF = 6'h01; // Gain 0.5.
   localparam logic [5:0] GAIN_X2_1 = 6'h02; // Gain 1.
   localparam logic [5:0] GAIN_X2_2 = 6'h04; // Gain 2.
   localparam logic [5:0] GAIN_X2_4 = 6'h08; // Gain 4.
   localparam logic [5:0] GAIN_X2_8 = 6'h10; // Gain 8.
   localparam logic [5:0] GAIN_X2_16 = 6'h20; // Gain 16.
   // Sequence lengths in SAR clocks.
   localparam logic [4:0] TRACK_SAR_CLOCKS = 5'h03; // Low-power tracking time.
   localparam logic [4:0] CONV_SAR_CLOCKS = 5'h10; // Conversion time.
   // Sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} state_t;
endpackage

// *** sar_clock_gen.sv ***
// SAR clock generator: one tick per SAR clock period.
`timescale 1ns/10ps
module sar_clock_gen (
   input wire logic clk, // System clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [4:0] divider, // Divider field D.
   input wire logic restart, // Starts a fresh full period.
   output logic sar_tick // High once per SAR clock period.
);
   typedef struct packed {
      logic [5:0] cnt; // Position within the period.
   } div_state_t;
   div_state_t r; // Registered state.
   div_state_t next_r; // Next state.
   logic [5:0] last; // Last count of a period, 2(D+1)-1.

   // A period lasts 2(D+1) system clocks.
   assign last = {divider, 1'b1};

   // Tick every clock with no division, else at the end of each period.
   // The tick does not look at restart: restart is itself made from the tick.
   assign sar_tick = (divider == 5'h00) || (r.cnt == last);

   // Counter advances and wraps; restart aligns the period to a start.
   always_comb begin
      next_r = r;
      if (restart || r.cnt == last) begin
         next_r.cnt = 6'h00;
      end else begin
         next_r.cnt = r.cnt + 6'h01;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // A divided clock never ticks on two adjacent cycles.
   property p_div_gap;
      sar_tick && divider != 5'h00 && $stable(divider) |=> !sar_tick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("divided tick too close");

   // No division means a tick every cycle.
   property p_no_div;
      divider == 5'h00 |-> sar_tick;
   endproperty
   a_no_div: assert property (p_no_div) else $error("undivided tick missing");
endmodule // sar_clock_gen

// *** window_compare.sv ***
// Window comparator for converter results.
`timescale 1ns/10ps
module window_compare (
   input wire logic [15:0] data_word, // Formatted result word.
   input wire logic [15:0] upper_word, // Greater-than reference.
   input wire logic [15:0] lower_word, // Less-than reference.
   input wire logic signed_mode, // Words are two's complement.
   output logic match // Result lies in the flagged region.
);
   logic above; // Result is above the greater-than word.
   logic below; // Result is below the less-than word.
   logic inside_mode; // Less-than word exceeds greater-than word.

   // Compare with the same signedness as the data word.
   always_comb begin
      if (signed_mode) begin
         above = $signed(data_word) > $signed(upper_word);
         below = $signed(data_word) < $signed(lower_word);
         inside_mode = $signed(lower_word) > $signed(upper_word);
      end else begin
         above = data_word > upper_word;
         below = data_word < lower_word;
         inside_mode = lower_word > upper_word;
      end
   end

   // Inside the limits when ordered that way, otherwise outside them.
   assign match = inside_mode ? (above && below) : (above || below);
endmodule // window_compare

// *** sar_adc_control.sv ***
// Control, sequencing and registers around a 12-bit SAR converter.
// Summary of operation
// - SAR clock is system clock over 2(D+1).
// - Divider zero runs SAR clock undivided.
// - Gain field decodes to 1,2,4,8,16,0.5.
// - Enable clear means shutdown, no conversions.
// - Normal mode tracks except while converting.
// - Done flag set as busy falls.
// - Busy bit reads one while converting.
// - Busy write of one starts in source 00.
// - Source field picks write, timers or pin.
// - Low-power mode tracks three SAR clocks first, except with the pin source.
// - Pin source tracks while low, converts rising.
// - Window flag set on match, software clears.
// - Right justify, sign-extend differential upper nibble.
// - Left justify, low nibble reads zero.
// - Single-ended unsigned, differential two's complement.
// - Compare results against both window words.
// - Conversion lasts sixteen SAR clocks.
`timescale 1ns/10ps
module sar_adc_control (
   input wire logic clk, // System clock, 50 MHz.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [7:0] sfr_addr, // Register address.
   input wire logic sfr_wr, // Write strobe.
   input wire logic sfr_rd, // Read strobe.
   input wire logic [7:0] sfr_wdata, // Write data.
   output logic [7:0] sfr_rdata, // Read data, one cycle after the strobe.
   input wire logic timer2_overflow, // Timer 2 overflow pulse.
   input wire logic timer3_overflow, // Timer 3 overflow pulse.
   input wire logic external_convert_start, // External start pin.
   input wire logic [11:0] sar_code, // Raw code from the analog SAR.
   input wire logic differential_mode, // Selected input is a differential pair.
   output logic converter_powered, // Analog section powered.
   output logic track_active, // Track-and-hold is tracking.
   output logic convert_active, // Analog SAR is converting.
   output logic sar_tick, // One pulse per SAR clock.
   output logic [5:0] pga_gain_x2, // Amplifier gain times two.
   output logic conversion_done_flag, // Conversion done flag.
   output logic window_match_flag // Window match flag.
);
   typedef struct packed {
      sar_adc_pkg::state_t st; // Sequencer state.
      logic [4:0] cnt; // SAR clocks spent in the state.
      logic [7:0] cfg; // Configuration register.
      logic en; // Converter enable.
      logic tm; // Track mode select.
      logic done; // Conversion done flag.
      logic winf; // Window match flag.
      logic [1:0] src; // Start source select.
      logic ljust; // Left justify select.
      logic [7:0] res_hi; // Result high byte.
      logic [7:0] res_lo; // Result low byte.
      logic [7:0] gth; // Greater-than high byte.
      logic [7:0] gtl; // Greater-than low byte.
      logic [7:0] lth; // Less-than high byte.
      logic [7:0] ltl; // Less-than low byte.
      logic [7:0] rdata; // Read data.
      logic ext_s1; // Pin synchroniser, first stage.
      logic ext_s2; // Pin synchroniser, second stage.
      logic ext_prev; // Previous synchronised pin level.
   } ctl_state_t;

   ctl_state_t r; // Registered state.
   ctl_state_t next_r; // Next state.
   logic busy; // Conversion in progress.
   logic ext_rise; // Rising edge of the synchronised pin.
   logic trigger; // Selected start event.
   logic ctl_wr; // Write to the control register.
   logic restart; // Aligns the SAR clock to a new phase.
   logic conv_end; // Last cycle of a conversion.
   logic win_hit; // Window comparator verdict.
   logic [15:0] fmt_word; // Justified result of the current code.
   logic [3:0] sign_fill; // Upper nibble for right justification.

   // Busy covers the tracking phase of low-power mode too.
   assign busy = r.st != sar_adc_pkg::ST_IDLE;
   assign ext_rise = r.ext_s2 && !r.ext_prev;
   assign ctl_wr = sfr_wr && sfr_addr == sar_adc_pkg::CONTROL_ADDR;

   // Select the start event from the source field.
   always_comb begin
      case (r.src)
         sar_adc_pkg::SRC_WRITE: trigger = ctl_wr && sfr_wdata[sar_adc_pkg::BUSY_BIT];
         sar_adc_pkg::SRC_TIMER3: trigger = timer3_overflow;
         sar_adc_pkg::SRC_PIN: trigger = ext_rise;
         default: trigger = timer2_overflow;
      endcase
   end

   // Differential codes fill the upper nibble with their sign.
   assign sign_fill = differential_mode ? {4{sar_code[11]}} : 4'h0;

   // Right or left justification of the raw code.
   assign fmt_word = r.ljust ? {sar_code, 4'h0}
      : {sign_fill, sar_code};

   // The window is judged on the word that is about to be stored.
   window_compare u_window (
      .data_word(fmt_word),
      .upper_word({r.gth, r.gtl}),
      .lower_word({r.lth, r.ltl}),
      .signed_mode(differential_mode),
      .match(win_hit)
   );

   // SAR clock ticks, restarted at each tracking or conversion start.
   sar_clock_gen u_sar_clock (
      .clk(clk),
      .arst_n(arst_n),
      .divider(r.cfg[sar_adc_pkg::DIV_MSB:sar_adc_pkg::DIV_LSB]),
      .restart(restart),
      .sar_tick(sar_tick)
   );

   // Decode the gain field; 10x and 11x ignore the lowest bit.
   always_comb begin
      if (r.cfg[sar_adc_pkg::GAIN_MSB]) begin
         pga_gain_x2 = r.cfg[sar_adc_pkg::GAIN_MSB - 1] ? sar_adc_pkg::GAIN_X2_HALF
            : sar_adc_pkg::GAIN_X2_16;
      end else begin
         case (r.cfg[sar_adc_pkg::GAIN_MSB - 1:0])
            2'h0: pga_gain_x2 = sar_adc_pkg::GAIN_X2_1;
            2'h1: pga_gain_x2 = sar_adc_pkg::GAIN_X2_2;
            2'h2: pga_gain_x2 = sar_adc_pkg::GAIN_X2_4;
            default: pga_gain_x2 = sar_adc_pkg::GAIN_X2_8;
         endcase
      end
   end

   // Analog controls follow the sequencer and the mode bits.
   assign converter_powered = r.en;
   assign convert_active = r.st == sar_adc_pkg::ST_CONV;
   always_comb begin
      if (!r.en) begin
         track_active = 1'b0;
      end else if (!r.tm) begin
         track_active = r.st != sar_adc_pkg::ST_CONV;
      end else if (r.src == sar_adc_pkg::SRC_PIN) begin
         track_active = r.st == sar_adc_pkg::ST_IDLE && !r.ext_s2;
      end else begin
         track_active = r.st == sar_adc_pkg::ST_TRACK;
      end
   end

   assign conversion_done_flag = r.done;
   assign window_match_flag = r.winf;
   assign sfr_rdata = r.rdata;

   // Register writes, read capture, sequencer and flag updates.
   always_comb begin
      next_r = r;
      restart = 1'b0;
      conv_end = 1'b0;
      // Pin passes two flip-flops before the edge detector sees it.
      next_r.ext_s1 = external_convert_start;
      next_r.ext_s2 = r.ext_s1;
      next_r.ext_prev = r.ext_s2;
      // Software writes; the busy bit itself is not stored.
      if (sfr_wr) begin
         if (sfr_addr == sar_adc_pkg::CONFIG_ADDR) begin
            next_r.cfg = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::RESULT_LOW_ADDR) begin
            next_r.res_lo = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::RESULT_HIGH_ADDR) begin
            next_r.res_hi = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::UPPER_LOW_ADDR) begin
            next_r.gtl = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::UPPER_HIGH_ADDR) begin
            next_r.gth = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::LOWER_LOW_ADDR) begin
            next_r.ltl = sfr_wdata;
         end else if (sfr_addr == sar_adc_pkg::LOWER_HIGH_ADDR) begin
            next_r.lth = sfr_wdata;
         end else if (ctl_wr) begin
            next_r.en = sfr_wdata[sar_adc_pkg::ENABLE_BIT];
            next_r.tm = sfr_wdata[sar_adc_pkg::TRACK_BIT];
            next_r.done = sfr_wdata[sar_adc_pkg::DONE_BIT];
            next_r.src = sfr_wdata[sar_adc_pkg::SOURCE_MSB:sar_adc_pkg::SOURCE_LSB];
            next_r.winf = sfr_wdata[sar_adc_pkg::WINDOW_BIT];
            next_r.ljust = sfr_wdata[sar_adc_pkg::LJUST_BIT];
         end
      end
      // Read data is captured on the strobe; unmapped reads give zero.
      if (sfr_rd) begin
         if (sfr_addr == sar_adc_pkg::CONFIG_ADDR) begin
            next_r.rdata = r.cfg;
         end else if (sfr_addr == sar_adc_pkg::RESULT_LOW_ADDR) begin
            next_r.rdata = r.res_lo;
         end else if (sfr_addr == sar_adc_pkg::RESULT_HIGH_ADDR) begin
            next_r.rdata = r.res_hi;
         end else if (sfr_addr == sar_adc_pkg::UPPER_LOW_ADDR) begin
            next_r.rdata = r.gtl;
         end else if (sfr_addr == sar_adc_pkg::UPPER_HIGH_ADDR) begin
            next_r.rdata = r.gth;
         end else if (sfr_addr == sar_adc_pkg::LOWER_LOW_ADDR) begin
            next_r.rdata = r.ltl;
         end else if (sfr_addr == sar_adc_pkg::LOWER_HIGH_ADDR) begin
            next_r.rdata = r.lth;
         end else if (sfr_addr == sar_adc_pkg::CONTROL_ADDR) begin
            next_r.rdata = {r.en, r.tm, r.done, busy, r.src, r.winf, r.ljust};
         end else begin
            next_r.rdata = sar_adc_pkg::ZERO_BYTE;
         end
      end
      // Sequencer, counting whole SAR clock periods.
      case (r.st)
         sar_adc_pkg::ST_IDLE: begin
            // Starts are accepted only while enabled and idle.
            if (r.en && trigger) begin
               restart = 1'b1;
               next_r.cnt = 5'h00;
               if (r.tm && r.src != sar_adc_pkg::SRC_PIN) begin
                  next_r.st = sar_adc_pkg::ST_TRACK;
               end else begin
                  next_r.st = sar_adc_pkg::ST_CONV;
               end
            end
         end
         sar_adc_pkg::ST_TRACK: begin
            // Track three SAR clocks, then convert.
            if (sar_tick) begin
               if (r.cnt == sar_adc_pkg::TRACK_SAR_CLOCKS - 5'h01) begin
                  restart = 1'b1;
                  next_r.cnt = 5'h00;
                  next_r.st = sar_adc_pkg::ST_CONV;
               end else begin
                  next_r.cnt = r.cnt + 5'h01;
               end
            end
         end
         default: begin
            // Conversion ends after sixteen full SAR clock periods.
            if (sar_tick) begin
               if (r.cnt == sar_adc_pkg::CONV_SAR_CLOCKS - 5'h01) begin
                  conv_end = 1'b1;
                  next_r.st = sar_adc_pkg::ST_IDLE;
               end else begin
                  next_r.cnt = r.cnt + 5'h01;
               end
            end
         end
      endcase
      // Clearing the enable aborts any conversion without a result.
      if (!r.en) begin
         next_r.st = sar_adc_pkg::ST_IDLE;
         conv_end = 1'b0;
      end
      // Completion stores the result and sets flags; set wins over clear.
      if (conv_end) begin
         next_r.res_hi = fmt_word[15:8];
         next_r.res_lo = fmt_word[7:0];
         next_r.done = 1'b1;
         if (win_hit) begin
            next_r.winf = 1'b1;
         end
      end
   end

   // State register with documented reset values.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.st <= sar_adc_pkg::ST_IDLE;
         r.cfg <= sar_adc_pkg::CONFIG_RESET;
         r.gth <= sar_adc_pkg::UPPER_RESET;
         r.gtl <= sar_adc_pkg::UPPER_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Helper counts of SAR clocks spent tracking and converting.
   logic [4:0] trk_ticks; // Ticks seen in the tracking state.
   logic [4:0] conv_ticks; // Ticks seen in the converting state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trk_ticks <= 5'h00;
         conv_ticks <= 5'h00;
      end else begin
         if (r.st == sar_adc_pkg::ST_TRACK && sar_tick) begin
            trk_ticks <= trk_ticks + 5'h01;
         end else if (r.st == sar_adc_pkg::ST_IDLE) begin
            trk_ticks <= 5'h00;
         end
         if (r.st == sar_adc_pkg::ST_CONV && sar_tick) begin
            conv_ticks <= conv_ticks + 5'h01;
         end else if (r.st != sar_adc_pkg::ST_CONV) begin
            conv_ticks <= 5'h00;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Gain codes 10x decode to sixteen.
   property p_gain16;
      r.cfg[sar_adc_pkg::GAIN_MSB:sar_adc_pkg::GAIN_MSB - 1] == 2'h2
         |-> pga_gain_x2 == sar_adc_pkg::GAIN_X2_16;
   endproperty
   a_gain16: assert property (p_gain16) else $error("gain 16 decode wrong");

   // A disabled converter is idle one cycle later.
   property p_shutdown;
      !r.en |=> !busy && !convert_active;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("busy while disabled");

   // Normal mode tracks whenever enabled and not converting.
   property p_track_cont;
      r.en && !r.tm && !convert_active |-> track_active;
   endproperty
   a_track_cont: assert property (p_track_cont) else $error("tracking lost");

   // A completed conversion sets done and loads the result together.
   property p_done_fall;
      $fell(busy) && $past(r.en) |-> r.done && r.res_lo == $past(fmt_word[7:0]);
   endproperty
   a_done_fall: assert property (p_done_fall) else $error("done or result missing");

   // The busy bit reads back the sequencer state.
   property p_busy_read;
      sfr_rd && sfr_addr == sar_adc_pkg::CONTROL_ADDR
         |=> sfr_rdata[sar_adc_pkg::BUSY_BIT] == $past(busy);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");

   // A software start in source 00 raises busy next cycle.
   sequence s_sw_start;
      r.en && !busy && r.src == sar_adc_pkg::SRC_WRITE && ctl_wr
         && sfr_wdata[sar_adc_pkg::BUSY_BIT];
   endsequence
   property p_sw_start;
      s_sw_start |=> busy;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("software start ignored");

   // A timer 3 overflow in normal mode starts converting at once.
   property p_timer3;
      r.en && !busy && !r.tm && r.src == sar_adc_pkg::SRC_TIMER3 && timer3_overflow
         |=> convert_active;
   endproperty
   a_timer3: assert property (p_timer3) else $error("timer start ignored");

   // Tracking in low-power mode lasts three SAR clocks.
   sequence s_track_over;
      r.st == sar_adc_pkg::ST_TRACK ##1 r.st == sar_adc_pkg::ST_CONV;
   endsequence
   property p_track3;
      s_track_over |-> $past(trk_ticks) == sar_adc_pkg::TRACK_SAR_CLOCKS - 5'h01;
   endproperty
   a_track3: assert property (p_track3) else $error("tracking length wrong");

   // A normal end of conversion follows exactly sixteen SAR clocks.
   property p_conv16;
      $fell(convert_active) && $past(r.en)
         |-> $past(conv_ticks) == sar_adc_pkg::CONV_SAR_CLOCKS - 5'h01;
   endproperty
   a_conv16: assert property (p_conv16) else $error("conversion length wrong");

   // A window hit at completion sets the window flag.
   property p_window;
      conv_end && win_hit |=> r.winf;
   endproperty
   a_window: assert property (p_window) else $error("window flag missing");

   // Left justified results leave the low nibble zero.
   property p_ljust;
      conv_end && r.ljust |=> r.res_lo[3:0] == 4'h0;
   endproperty
   a_ljust: assert property (p_ljust) else $error("low nibble not zero");
endmodule // sar_adc_control

// *** tb_sar_adc_control.sv ***
// Self-checking bench for the SAR converter control block.
`timescale 1ns/10ps
module tb_sar_adc_control;
   logic clk, arst_n, sfr_wr, sfr_rd, tmr2, tmr3, pin, diff; // Driven inputs.
   logic [7:0] addr, wdata, rdata, b; // Register port and read byte.
   logic [11:0] code; // Raw code offered by the analog side.
   logic powered, tracking, converting, tick, done, wflag; // Status outputs.
   logic [5:0] gain; // Decoded gain times two.
   logic [15:0] w, gt, lt; // Model data and window words.
   logic [5:0] gtab [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01}; // Gains.
   int fails = 0, checks_done = 0, seed = 98, n, p, wi, gi, li, m; // Counters and model.

   sar_adc_control sar_adc_control_inst (.clk(clk), .arst_n(arst_n), .sfr_addr(addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
      .timer2_overflow(tmr2), .timer3_overflow(tmr3), .external_convert_start(pin),
      .sar_code(code), .differential_mode(diff), .converter_powered(powered),
      .track_active(tracking), .convert_active(converting), .sar_tick(tick),
      .pga_gain_x2(gain), .conversion_done_flag(done), .window_match_flag(wflag));

   // The clock toggles every 10 ns, half of its 20 ns period.
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   // Compares one value and counts the result.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Issues a one-cycle pulse on a strobe-like input.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      sfr_wr <= 1'h1;
      @(posedge clk);
      sfr_wr <= 1'h0;
   endtask

   // Reads one register; data is taken one cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      sfr_rd <= 1'h1;
      @(posedge clk);
      sfr_rd <= 1'h0;
      #1 b = rdata;
   endtask

   // Runs one conversion and compares results and flags with the model.
   task automatic conv(input logic [1:0] src, input logic tm, input logic [4:0] dv);
      logic lj;
      lj = $random(seed);
      gt = $random(seed);
      lt = $random(seed);
      wr(8'hbc, {dv, 3'h0});
      code <= $random(seed);
      diff <= $random(seed);
      wr(8'hc4, gt[7:0]);
      wr(8'hc5, gt[15:8]);
      wr(8'hc6, lt[7:0]);
      wr(8'hc7, lt[15:8]);
      wr(8'he8, {1'h1, tm, 2'h0, src, 1'h0, lj});
      // A write start needs the source already stored as 00, so it comes second.
      if (src == 2'h0) wr(8'he8, {1'h1, tm, 2'h1, src, 1'h0, lj});
      // Timer sources get a separate one-cycle trigger pulse; the pin is raised and held high until the task ends.
      else begin
         @(posedge clk);
         tmr3 <= (src == 2'h1);
         tmr2 <= (src == 2'h3);
         pin <= (src == 2'h2);
         @(posedge clk);
         tmr3 <= 1'h0;
         tmr2 <= 1'h0;
      end
      n = 0;
      while (done !== 1'h1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      p = (dv == 5'h00) ? 1 : 2 * (dv + 1);
      if (src != 2'h2) check(n, p * (16 + (tm ? 3 : 0)));
      check(done, 1'h1);
      check(tick, dv == 5'h00);
      w = lj ? {code, 4'h0} : {(diff ? {4{code[11]}} : 4'h0), code};
      wi = diff ? int'(signed'(w)) : int'(w);
      gi = diff ? int'(signed'(gt)) : int'(gt);
      li = diff ? int'(signed'(lt)) : int'(lt);
      m = (li > gi) ? (wi > gi && wi < li) : (wi > gi || wi < li);
      check(wflag, m);
      if (!tm) check({tracking, converting}, 2'h2);
      rd(8'hbf);
      check(b, w[15:8]);
      rd(8'hbe);
      check(b, w[7:0]);
      rd(8'he8);
      check(b, {1'h1, tm, 1'h1, 1'h0, src, m[0], lj});
      @(posedge clk) pin <= 1'h0;
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      results();
   end

   // Main sequence: reset values, gain decode, refused starts, conversions.
   initial begin
      {addr, wdata, sfr_wr, sfr_rd, tmr2, tmr3, pin, diff, code, arst_n} = '0;
      repeat (5) @(posedge clk);
      arst_n <= 1'h1;
      rd(8'hbc);
      check(b, 8'hf8);
      rd(8'hc5);
      check(b, 8'hff);
      rd(8'h00);
      check(b, 8'h00);
      check(gain, 6'h02);
      for (int g = 0; g < 8; g++) begin
         wr(8'hbc, {5'h1f, g[2:0]});
         #1 check(gain, gtab[g]);
      end
      // A start while disabled, and a write start under a timer source, are ignored.
      wr(8'he8, 8'h10);
      repeat (40) @(posedge clk);
      rd(8'he8);
      check({b, powered}, 9'h000);
      wr(8'he8, 8'h84);
      wr(8'he8, 8'h94);
      repeat (40) @(posedge clk);
      rd(8'he8);
      check(b, 8'h84);
      for (int i = 0; i < 12; i++) conv(i % 4, (i / 4) == 1, (i >= 8) ? 5'h09 : 5'h00);
      results();
   end
endmodule // tb_sar_adc_control
